// ==== src/panel_scan_pkg.sv ====
// Shared constants of the panel scan timing controller.
package panel_scan_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock rate and the sample clock divider.
  localparam real PCLK_MHZ   = 20.0; // System clock rate in MHz.
  localparam int  SAMPLE_DIV = 2;    // System cycles per sample clock period.

  ////////////////////////////////////////////////////////////////////////////
  // Line and field figures, in their own units and in system cycles.
  localparam real LINE_US       = 63.5;
  localparam int  LINE_CYC      = int'(LINE_US * PCLK_MHZ);
  localparam int  HALF_CYC      = LINE_CYC / 2;
  localparam real FIELD_LINES   = 262.5;
  localparam int  FIELD_HALVES  = int'(FIELD_LINES * 2.0);
  localparam real SOE_US        = 8.0;
  localparam int  SOE_CYC       = int'(SOE_US * PCLK_MHZ);
  localparam real SS_GAP_US     = 0.5;
  localparam int  SS_GAP_CYC    = int'(SS_GAP_US * PCLK_MHZ);
  localparam real SS_NS         = 100.0;
  localparam int  SS_CYC        = int'(SS_NS * PCLK_MHZ / 1000.0);
  localparam real TOSP_US       = 0.11;
  localparam int  TOSP_CYC      = int'($ceil(TOSP_US * PCLK_MHZ));
  localparam real VIDEO_US      = 10.0;
  localparam int  VIDEO_CYC     = int'(VIDEO_US * PCLK_MHZ);
  localparam int  VIDEO_SAMPLES = 480;
  localparam int  VIDEO_LEN_CYC = VIDEO_SAMPLES * SAMPLE_DIV;
  localparam real TOC_US        = 2.3;
  localparam int  TOC_CYC       = int'(TOC_US * PCLK_MHZ);
  localparam real GSC_HIGH_US   = 10.3;
  localparam int  GSC_HIGH_CYC  = int'(GSC_HIGH_US * PCLK_MHZ);
  localparam real GOE_LEAD_US   = 1.5;
  localparam int  GOE_LEAD_CYC  = int'(GOE_LEAD_US * PCLK_MHZ);
  localparam real GOE_TRAIL_CLK = 3.0;
  localparam int  GOE_TRAIL_CYC = int'(GOE_TRAIL_CLK * SAMPLE_DIV);
  localparam real GS_SETUP_US   = 2.0;
  localparam int  GS_SETUP_CYC  = int'($ceil(GS_SETUP_US * PCLK_MHZ));

  ////////////////////////////////////////////////////////////////////////////
  // Counter types and the marks of the line, as positions in a line.
  localparam int POS_W   = 11;
  localparam int FIELD_W = 10;
  typedef logic [POS_W-1:0]   pos_t;
  typedef logic [FIELD_W-1:0] field_t;
  localparam pos_t   P_LAST     = pos_t'(LINE_CYC - 1);
  localparam pos_t   P_HALF     = pos_t'(HALF_CYC);
  localparam pos_t   P_SOE_OFF  = pos_t'(SOE_CYC);
  localparam pos_t   P_SS_ON    = pos_t'(SOE_CYC + SS_GAP_CYC);
  localparam pos_t   P_SS_OFF   = pos_t'(SOE_CYC + SS_GAP_CYC + SS_CYC);
  localparam pos_t   P_VID_ON   = pos_t'(VIDEO_CYC);
  localparam pos_t   P_VID_OFF  = pos_t'(VIDEO_CYC + VIDEO_LEN_CYC);
  localparam pos_t   P_GSC_ON   = pos_t'(SOE_CYC + TOC_CYC);
  localparam pos_t   P_GSC_OFF  = pos_t'(SOE_CYC + TOC_CYC + GSC_HIGH_CYC);
  localparam pos_t   P_GOE_ON   = pos_t'(SOE_CYC + TOC_CYC - GOE_LEAD_CYC);
  localparam pos_t   P_GOE_OFF  = pos_t'(SOE_CYC + TOC_CYC + GOE_TRAIL_CYC);
  localparam field_t FIELD_LAST = field_t'(FIELD_HALVES - 1);
  localparam field_t GS_LAST    = field_t'(1); // Start pulse spans two halves.

  ////////////////////////////////////////////////////////////////////////////
  // Register map of the controller's own registers and their fields.
  localparam int                ADDR_W        = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFS      = 12'h000;
  localparam logic [ADDR_W-1:0] STAT_OFS      = 12'h004;
  localparam logic [ADDR_W-1:0] POS_OFS       = 12'h008;
  localparam int                CTRL_RUN      = 0;
  localparam int                CTRL_SIMUL    = 1;
  localparam int                CTRL_VREV     = 2;
  localparam int                CTRL_HDIR     = 3;
  localparam logic              HDIR_RESET    = 1'b1;
  localparam int                STAT_RUN      = 0;
  localparam int                STAT_HOLD     = 1;
  localparam int                STAT_VSEEN    = 2;
  localparam int                STAT_HSEEN    = 3;
  localparam int                POS_FIELD_LSB = 16;

  // Scan sequencer states, Gray coded along idle, hold, scan.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_SCAN = 2'b11
  } scan_state_t;

endpackage : panel_scan_pkg

// ==== src/panel_scan_timing.sv ====
// Notes on behaviour
// - Gate enables held high one field at start.
// - Field lasts 262.5 lines, one start pulse.
// - Line period is 63.5 microseconds.
// - Sample clock runs within 1 to 10 MHz.
// - Sample clock phases high/low 47.1-57.5 ns.
// - Sequential phases each delayed after the previous.
// - Source start pulse 30 to 208 ns wide.
// - Source start setup 20 ns, hold 10 ns.
// - Source enable once per line, 7.5-8.5 us.
// - Video starts 1.59 to 11.11 us in.
// - Source enable to shift clock gap 2.3 us.
// - Source enable to source start gap 0.11 us.
// - Gate enable rises 1 to 2 us from shift.
// - Gate enable falls 2-4 sample clocks after shift.
// - Shift clock period 63.5 us, phases 5-58.5 us.
// - Gate start 5-126 us, 2 us setup/hold.
// - Vertical strap picks which gate start pin drives.
// - Horizontal strap picks which source start pin drives.
// - Mode strap high ties phases b, c high.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
module panel_scan_timing
  import panel_scan_pkg::*;
#(
  parameter logic [3:0] STARTUP_FIELDS = 4'h1, // Fields of gate enable hold.
  parameter field_t     FIELD_END      = FIELD_LAST // Last half of a field.
) (
  // Clock, reset and APB slave port.
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Source side of the panel.
  output logic                   sample_clock_phase_a,
  output logic                   sample_clock_phase_b,
  output logic                   sample_clock_phase_c,
  output logic                   sample_mode,
  output logic                   horizontal_scan_direction,
  input  wire logic              source_start_a_in,
  output logic                   source_start_a_out,
  output logic                   source_start_a_oe,
  input  wire logic              source_start_b_in,
  output logic                   source_start_b_out,
  output logic                   source_start_b_oe,
  output logic                   source_out_enable,
  output logic                   video_window,
  // Gate side of the panel.
  output logic                   gate_shift_clock,
  output logic                   vertical_scan_direction,
  input  wire logic              gate_start_a_in,
  output logic                   gate_start_a_out,
  output logic                   gate_start_a_oe,
  input  wire logic              gate_start_b_in,
  output logic                   gate_start_b_out,
  output logic                   gate_start_b_oe,
  output logic                   gate_out_enable_a,
  output logic                   gate_out_enable_b,
  output logic                   gate_out_enable_c
);

  ////////////////////////////////////////////////////////////////////////////
  // All state of the controller in one record.
  typedef struct packed {
    scan_state_t st;          // Sequencer state.
    pos_t        pos;         // Cycle within the line.
    field_t      field;       // Half line within the field.
    logic [3:0]  fields_done; // Whole fields seen while holding.
    logic        run;         // Software asks the scan to run.
    logic        simul;       // Simultaneous sampling strap level.
    logic        vrev;        // Vertical strap level, high is reverse.
    logic        hdir;        // Horizontal strap level, high is normal.
    logic        vseen;       // Gate start came back from the panel.
    logic        hseen;       // Source start came back from the panel.
    logic [2:0]  vsync;       // Synchroniser for the returned gate start.
    logic [2:0]  hsync;       // Synchroniser for the returned source start.
    logic        vfilt;       // Agreed level of the gate return.
    logic        hfilt;       // Agreed level of the source return.
    logic        pha;         // Sample clock, phase a.
    logic        phb;         // Sample clock, phase b.
    logic        phc;         // Sample clock, phase c.
    logic        ss;          // Source start pulse.
    logic        soe;         // Source output enable.
    logic        gsc;         // Gate shift clock.
    logic        gs;          // Gate start pulse.
    logic        goe;         // Gate output enables.
    logic        video;       // Window of valid video.
    logic        gs_a_oe;     // Drive enable of gate start pin a.
    logic        gs_b_oe;     // Drive enable of gate start pin b.
    logic        ss_a_oe;     // Drive enable of source start pin a.
    logic        ss_b_oe;     // Drive enable of source start pin b.
    logic        pready;      // APB ready, one cycle per access.
    logic        pslverr;     // APB error for an unmapped address.
    logic [31:0] prdata;      // APB read data.
  } ctl_t;

  ctl_t ctl_r;     // Registered state.
  ctl_t ctl_nxt;   // Next state.
  logic access;    // Access phase of an APB transfer.
  logic wr_ok;     // Write commits at this edge.
  logic half_step; // A half line begins in the next cycle.
  logic active;    // Scan runs in the next cycle.

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus slave, returned start pins, scan counters, pins.
  always_comb begin
    ctl_nxt   = ctl_r;
    access    = psel & penable;
    wr_ok     = access & ctl_r.pready & pwrite & pstrb[0];
    half_step = 1'b0;
    // Ready follows one wait cycle, so read data and error come from flops.
    ctl_nxt.pready  = access & ~ctl_r.pready;
    ctl_nxt.prdata  = 32'h0000_0000;
    ctl_nxt.pslverr = 1'b0;
    if (access && !ctl_r.pready) begin
      case (paddr)
        CTRL_OFS: begin
          ctl_nxt.prdata[CTRL_RUN]   = ctl_r.run;
          ctl_nxt.prdata[CTRL_SIMUL] = ctl_r.simul;
          ctl_nxt.prdata[CTRL_VREV]  = ctl_r.vrev;
          ctl_nxt.prdata[CTRL_HDIR]  = ctl_r.hdir;
        end
        STAT_OFS: begin
          ctl_nxt.prdata[STAT_RUN]   = (ctl_r.st != ST_IDLE);
          ctl_nxt.prdata[STAT_HOLD]  = (ctl_r.st == ST_HOLD);
          ctl_nxt.prdata[STAT_VSEEN] = ctl_r.vseen;
          ctl_nxt.prdata[STAT_HSEEN] = ctl_r.hseen;
        end
        POS_OFS: begin
          ctl_nxt.prdata[POS_W-1:0]                = ctl_r.pos;
          ctl_nxt.prdata[POS_FIELD_LSB +: FIELD_W] = ctl_r.field;
        end
        // Unmapped words read as zero and answer with an error.
        default: ctl_nxt.pslverr = 1'b1;
      endcase
    end
    // Strap levels may change while scanning; the panel sees it at once.
    if (wr_ok && paddr == CTRL_OFS) begin
      ctl_nxt.run   = pwdata[CTRL_RUN];
      ctl_nxt.simul = pwdata[CTRL_SIMUL];
      ctl_nxt.vrev  = pwdata[CTRL_VREV];
      ctl_nxt.hdir  = pwdata[CTRL_HDIR];
    end
    // The start pin the controller does not drive carries the panel's
    // cascade output; it is synchronised and seen once two stages agree.
    ctl_nxt.vsync = {ctl_r.vsync[1:0],
                     ctl_r.vrev ? gate_start_b_in : gate_start_a_in};
    ctl_nxt.hsync = {ctl_r.hsync[1:0],
                     ctl_r.hdir ? source_start_b_in : source_start_a_in};
    if (ctl_r.vsync[2] == ctl_r.vsync[1]) begin
      ctl_nxt.vfilt = ctl_r.vsync[1];
    end
    if (ctl_r.hsync[2] == ctl_r.hsync[1]) begin
      ctl_nxt.hfilt = ctl_r.hsync[1];
    end
    // Write one clears; a return arriving in the same cycle still sets.
    if (wr_ok && paddr == STAT_OFS) begin
      ctl_nxt.vseen = ctl_r.vseen & ~pwdata[STAT_VSEEN];
      ctl_nxt.hseen = ctl_r.hseen & ~pwdata[STAT_HSEEN];
    end
    ctl_nxt.vseen = ctl_nxt.vseen | (ctl_nxt.vfilt & ~ctl_r.vfilt);
    ctl_nxt.hseen = ctl_nxt.hseen | (ctl_nxt.hfilt & ~ctl_r.hfilt);
    // Scan sequencer: line counter of system cycles, field counter of half lines.
    case (ctl_r.st)
      ST_IDLE: begin
        if (ctl_r.run) begin
          ctl_nxt.st          = ST_HOLD;
          ctl_nxt.pos         = '0;
          ctl_nxt.field       = '0;
          ctl_nxt.fields_done = 4'h0;
        end
      end
      ST_HOLD, ST_SCAN: begin
        if (!ctl_r.run) begin
          ctl_nxt.st = ST_IDLE;
        end else begin
          ctl_nxt.pos = (ctl_r.pos == P_LAST) ? '0 : ctl_r.pos + 1'b1;
          half_step   = (ctl_nxt.pos == '0) || (ctl_nxt.pos == P_HALF);
          if (half_step) begin
            ctl_nxt.field = (ctl_r.field == FIELD_END) ? '0
                          : ctl_r.field + 1'b1;
          end
          // Each field wrap while holding counts one whole field.
          if (half_step && ctl_nxt.field == '0 && ctl_r.st == ST_HOLD) begin
            ctl_nxt.fields_done = ctl_r.fields_done + 4'h1;
            if (ctl_nxt.fields_done >= STARTUP_FIELDS) begin
              ctl_nxt.st = ST_SCAN;
            end
          end
        end
      end
      default: ctl_nxt.st = ST_IDLE;
    endcase
    active = (ctl_nxt.st != ST_IDLE);
    // Phase a toggles every cycle; line length is even so it never slips.
    ctl_nxt.pha = active & ctl_nxt.pos[0];
    // Phase b lags a by one cycle and c lags b; simultaneous ties them.
    ctl_nxt.phb = ctl_nxt.simul | ctl_r.pha;
    ctl_nxt.phc = ctl_nxt.simul | ctl_r.phb;
    // Source start straddles one rising edge of phase a.
    ctl_nxt.ss = active && ctl_nxt.pos >= P_SS_ON
              && ctl_nxt.pos < P_SS_OFF;
    ctl_nxt.soe = active && ctl_nxt.pos < P_SOE_OFF;
    ctl_nxt.video = active && ctl_nxt.pos >= P_VID_ON
                 && ctl_nxt.pos < P_VID_OFF;
    ctl_nxt.gsc = active && ctl_nxt.pos >= P_GSC_ON
               && ctl_nxt.pos < P_GSC_OFF;
    // Gate start covers the first two half lines of every field.
    ctl_nxt.gs = active && ctl_nxt.field <= GS_LAST;
    // Gate enables stay high until the hold ends, then pulse per line.
    ctl_nxt.goe = (ctl_nxt.st != ST_SCAN)
               || (ctl_nxt.pos >= P_GOE_ON && ctl_nxt.pos < P_GOE_OFF);
    ctl_nxt.gs_a_oe = ctl_nxt.vrev;
    ctl_nxt.gs_b_oe = ~ctl_nxt.vrev;
    ctl_nxt.ss_a_oe = ctl_nxt.hdir;
    ctl_nxt.ss_b_oe = ~ctl_nxt.hdir;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; gate enables reset high so the panel stays blanked.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r      <= '0;
      ctl_r.st   <= ST_IDLE;
      ctl_r.hdir <= HDIR_RESET;
      ctl_r.goe  <= 1'b1;
      ctl_r.ss_a_oe <= HDIR_RESET;
      ctl_r.ss_b_oe <= ~HDIR_RESET;
      ctl_r.gs_b_oe <= 1'b1;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flop of the record.
  assign prdata                    = ctl_r.prdata;
  assign pready                    = ctl_r.pready;
  assign pslverr                   = ctl_r.pslverr;
  assign sample_clock_phase_a      = ctl_r.pha;
  assign sample_clock_phase_b      = ctl_r.phb;
  assign sample_clock_phase_c      = ctl_r.phc;
  assign sample_mode               = ctl_r.simul;
  assign horizontal_scan_direction = ctl_r.hdir;
  assign source_start_a_out        = ctl_r.ss;
  assign source_start_a_oe         = ctl_r.ss_a_oe;
  assign source_start_b_out        = ctl_r.ss;
  assign source_start_b_oe         = ctl_r.ss_b_oe;
  assign source_out_enable         = ctl_r.soe;
  assign video_window              = ctl_r.video;
  assign gate_shift_clock          = ctl_r.gsc;
  assign vertical_scan_direction   = ctl_r.vrev;
  assign gate_start_a_out          = ctl_r.gs;
  assign gate_start_a_oe           = ctl_r.gs_a_oe;
  assign gate_start_b_out          = ctl_r.gs;
  assign gate_start_b_oe           = ctl_r.gs_b_oe;
  assign gate_out_enable_a         = ctl_r.goe;
  assign gate_out_enable_b         = ctl_r.goe;
  assign gate_out_enable_c         = ctl_r.goe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the pin timing.
  localparam int TOC_D  = TOC_CYC;
  localparam int TOC_D1 = TOC_CYC + 1;
  localparam int VID_D  = VIDEO_CYC;
  localparam int VID_D1 = VIDEO_CYC + 1;
  localparam int LEAD_D = GOE_LEAD_CYC;
  localparam int LEAD_1 = GOE_LEAD_CYC + 1;
  localparam int TOSP_D = TOSP_CYC;
  localparam int GS_D   = GS_SETUP_CYC;

  property p_hold_high;
    @(posedge pclk) disable iff (!presetn)
    (ctl_r.st == ST_HOLD) |-> gate_out_enable_a && gate_out_enable_c;
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("Hold dropped.");
  property p_hold_end;
    @(posedge pclk) disable iff (!presetn)
    (ctl_r.st == ST_SCAN && $past(ctl_r.st) == ST_HOLD)
      |-> ctl_r.field == '0 && $past(ctl_r.field) == FIELD_END;
  endproperty
  a_hold_end: assert property (p_hold_end) else $error("Hold end early.");
  property p_field;
    @(posedge pclk) disable iff (!presetn)
    $rose(gate_start_a_out)
      |-> ctl_r.field == '0 && (ctl_r.pos == '0 || ctl_r.pos == P_HALF);
  endproperty
  a_field: assert property (p_field) else $error("Field start off.");
  property p_line;
    @(posedge pclk) disable iff (!presetn)
    (ctl_r.st != ST_IDLE && $past(ctl_r.st) != ST_IDLE && ctl_r.pos == '0)
      |-> $past(ctl_r.pos) == P_LAST && source_out_enable;
  endproperty
  a_line: assert property (p_line) else $error("Line length off.");
  property p_toggle;
    @(posedge pclk) disable iff (!presetn)
    (ctl_r.st != ST_IDLE && $past(ctl_r.st) != ST_IDLE)
      |-> sample_clock_phase_a != $past(sample_clock_phase_a);
  endproperty
  a_toggle: assert property (p_toggle) else $error("Phase a stuck.");
  property p_seq;
    @(posedge pclk) disable iff (!presetn)
    (!sample_mode && !$past(sample_mode))
      |-> sample_clock_phase_b == $past(sample_clock_phase_a)
       && sample_clock_phase_c == $past(sample_clock_phase_b);
  endproperty
  a_seq: assert property (p_seq) else $error("Phase lag wrong.");
  property p_sstart;
    @(posedge pclk) disable iff (!presetn)
    $rose(source_start_a_out) |-> !sample_clock_phase_a
      ##1 (source_start_a_out && sample_clock_phase_a)
      ##1 !source_start_a_out;
  endproperty
  a_sstart: assert property (p_sstart) else $error("Start pulse off.");
  property p_soe;
    @(posedge pclk) disable iff (!presetn)
    ($fell(source_out_enable) && ctl_r.st != ST_IDLE)
      |-> ctl_r.pos == P_SOE_OFF;
  endproperty
  a_soe: assert property (p_soe) else $error("Enable width off.");
  property p_video;
    @(posedge pclk) disable iff (!presetn)
    $rose(video_window) |-> $past(source_out_enable, VID_D)
      && !$past(source_out_enable, VID_D1);
  endproperty
  a_video: assert property (p_video) else $error("Video start off.");
  property p_toc;
    @(posedge pclk) disable iff (!presetn)
    $rose(gate_shift_clock) |-> !$past(source_out_enable, TOC_D)
      && $past(source_out_enable, TOC_D1);
  endproperty
  a_toc: assert property (p_toc) else $error("Shift gap off.");
  property p_tosp;
    @(posedge pclk) disable iff (!presetn)
    $rose(source_start_a_out) |-> !$past(source_out_enable, TOSP_D);
  endproperty
  a_tosp: assert property (p_tosp) else $error("Start too close.");
  property p_goe_rise;
    @(posedge pclk) disable iff (!presetn)
    ($rose(gate_shift_clock) && $past(ctl_r.st, LEAD_1) == ST_SCAN)
      |-> $past(gate_out_enable_b, LEAD_D)
       && !$past(gate_out_enable_b, LEAD_1);
  endproperty
  a_goe_rise: assert property (p_goe_rise) else $error("Gate lead off.");
  property p_goe_fall;
    @(posedge pclk) disable iff (!presetn)
    ($rose(gate_shift_clock) && ctl_r.st == ST_SCAN && ctl_r.run)
      |-> gate_out_enable_b[*6] ##1 !gate_out_enable_b;
  endproperty
  a_goe_fall: assert property (p_goe_fall) else $error("Gate trail off.");
  property p_gsc;
    @(posedge pclk) disable iff (!presetn)
    ($fell(gate_shift_clock) && ctl_r.st != ST_IDLE)
      |-> ctl_r.pos == P_GSC_OFF;
  endproperty
  a_gsc: assert property (p_gsc) else $error("Shift width off.");
  property p_gs_setup;
    @(posedge pclk) disable iff (!presetn)
    ($rose(gate_shift_clock) && gate_start_b_out)
      |-> $past(gate_start_b_out, GS_D);
  endproperty
  a_gs_setup: assert property (p_gs_setup) else $error("Gate setup.");
  property p_dirs;
    @(posedge pclk) disable iff (!presetn)
    gate_start_a_oe == vertical_scan_direction
      && gate_start_b_oe != vertical_scan_direction
      && source_start_a_oe == horizontal_scan_direction
      && source_start_b_oe != horizontal_scan_direction;
  endproperty
  a_dirs: assert property (p_dirs) else $error("Pin roles wrong.");
  property p_simul;
    @(posedge pclk) disable iff (!presetn)
    sample_mode |-> sample_clock_phase_b && sample_clock_phase_c;
  endproperty
  a_simul: assert property (p_simul) else $error("Phases not tied.");

endmodule : panel_scan_timing

// ==== test/panel_model.sv ====
`timescale 1ns/1ps
// Panel start path: the pulse taken on one pin comes back on the other.
module panel_model (
  // Clock and direction straps.
  input  wire logic       pclk,
  input  wire logic       hdir,
  input  wire logic       vrev,
  // Start pins as split by the controller; index 0 is pin a.
  input  wire logic [1:0] ss_o,
  input  wire logic [1:0] ss_oe,
  input  wire logic [1:0] gs_o,
  input  wire logic [1:0] gs_oe,
  output logic      [1:0] ss_i,
  output logic      [1:0] gs_i
);
  logic [3:0] sd_r = '0; // Source shift chain, a few cycles of delay.
  logic [3:0] gd_r = '0; // Gate shift chain.
  // The straps choose which pin the panel takes its pulse from.
  always_ff @(posedge pclk) begin
    sd_r <= {sd_r[2:0], hdir ? ss_o[0] : ss_o[1]};
    gd_r <= {gd_r[2:0], vrev ? gs_o[0] : gs_o[1]};
  end
  // A pin nobody drives shows the inverse, so it never reads as valid.
  assign ss_i[0] = ss_oe[0] ? ss_o[0] : (hdir ? ~ss_o[0] : sd_r[3]);
  assign ss_i[1] = ss_oe[1] ? ss_o[1] : (hdir ? sd_r[3] : ~ss_o[1]);
  assign gs_i[0] = gs_oe[0] ? gs_o[0] : (vrev ? ~gs_o[0] : gd_r[3]);
  assign gs_i[1] = gs_oe[1] ? gs_o[1] : (vrev ? gd_r[3] : ~gs_o[1]);
endmodule : panel_model

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import panel_scan_pkg::*;
  // Bus side; byte strobes stay all set.
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, e;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  // Panel pins.
  logic sample_clock_phase_a, sample_clock_phase_b, sample_clock_phase_c;
  logic sample_mode, horizontal_scan_direction, vertical_scan_direction;
  logic source_start_a_out, source_start_a_oe, source_start_b_out;
  logic source_start_b_oe, source_out_enable, video_window;
  logic gate_shift_clock, gate_start_a_out, gate_start_a_oe;
  logic gate_start_b_out, gate_start_b_oe, gate_out_enable_a;
  logic gate_out_enable_b, gate_out_enable_c;
  logic [1:0] ss_i, gs_i;
  wire source_start_a_in = ss_i[0], source_start_b_in = ss_i[1];
  wire gate_start_a_in = gs_i[0], gate_start_b_in = gs_i[1];
  int error_cnt = 0, samples_checked = 0;
  always #25 pclk = ~pclk;
  // A short field of eleven half lines lets the hold end within the run.
  panel_scan_timing #(.FIELD_END(field_t'(10))) dut (.*);
  panel_model pm (.pclk(pclk), .hdir(horizontal_scan_direction),
    .vrev(vertical_scan_direction), .ss_i(ss_i), .gs_i(gs_i),
    .ss_o({source_start_b_out, source_start_a_out}),
    .ss_oe({source_start_b_oe, source_start_a_oe}),
    .gs_o({gate_start_b_out, gate_start_a_out}),
    .gs_oe({gate_start_b_oe, gate_start_a_oe}));
  ////////////////////////////////////////////////////////////////////////////
  // Compare one value and count it.
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time, g, x);
    end
  endtask : chk
  // One APB transfer; the wait is bounded so a dead slave cannot hang us.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n == 50) error_cnt++;
    rd = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  ////////////////////////////////////////////////////////////////////////////
  // Pins after reset, control reset value, and an unmapped access.
  task automatic t_reset;
    chk({horizontal_scan_direction, vertical_scan_direction, sample_mode,
      gate_out_enable_a, source_start_a_oe, gate_start_b_oe}, 6'h27);
    apb(0, CTRL_OFS, 0);
    chk(rd, 32'h8);
    apb(0, 12'hFFC, 0);
    chk(e, 1);
    chk(rd, 0);
  endtask : t_reset
  // Start the scan and check every cycle of a whole line plus one.
  task automatic t_line;
    int n, q;
    logic pa, pb;
    n = 0;
    apb(1, CTRL_OFS, 1);
    do begin
      pa = sample_clock_phase_a;
      pb = sample_clock_phase_b;
      @(negedge pclk);
    end while (source_out_enable !== 1'b1 && ++n < 100);
    if (n == 100) error_cnt++;
    for (int p = 0; p <= LINE_CYC; p++) begin
      q = p % LINE_CYC;
      chk({source_out_enable, source_start_a_out, gate_shift_clock,
        video_window, gate_out_enable_a & gate_out_enable_b &
        gate_out_enable_c}, {q < P_SOE_OFF, q >= P_SS_ON && q < P_SS_OFF,
        q >= P_GSC_ON && q < P_GSC_OFF, q >= P_VID_ON && q < P_VID_OFF,
        1'b1});
      chk({sample_clock_phase_b, sample_clock_phase_c}, {pa, pb});
      if (q == P_SS_ON || q == P_SS_ON + 1)
        chk(sample_clock_phase_a, q != P_SS_ON);
      pa = sample_clock_phase_a;
      pb = sample_clock_phase_b;
      @(negedge pclk);
    end
    // Position 3 of the second line, which is half line 2 of the field.
    apb(0, POS_OFS, 0);
    chk(rd, 32'h0002_0003);
    apb(0, STAT_OFS, 0);
    chk(rd[3:0], 4'hF);
  endtask : t_line
  // Swap both straps; the pulse must return on the other source pin.
  task automatic t_dir;
    apb(1, STAT_OFS, 32'hC);
    apb(1, CTRL_OFS, 32'h5);
    @(negedge pclk);
    chk({source_start_a_oe, source_start_b_oe, gate_start_a_oe,
      gate_start_b_oe, horizontal_scan_direction,
      vertical_scan_direction}, 6'h19);
    repeat (LINE_CYC + 20) @(negedge pclk);
    apb(0, STAT_OFS, 0);
    chk(rd[3:0], 4'hB);
  endtask : t_dir
  // Wait out the hold, then gate enable b must pulse once in one whole line.
  task automatic t_scan;
    int n;
    n = 0;
    do apb(0, STAT_OFS, 0); while (rd[1] && ++n < 3000);
    chk(rd[1:0], 1);
    @(negedge pclk);
    while (source_out_enable) @(negedge pclk);
    while (!source_out_enable) @(negedge pclk);
    for (int p = 0; p < LINE_CYC; p++) begin
      chk(gate_out_enable_b, p >= P_GOE_ON && p < P_GOE_OFF);
      @(negedge pclk);
    end
  endtask : t_scan
  // Simultaneous mode ties phases b and c high, then stop the scan.
  task automatic t_mode;
    apb(1, CTRL_OFS, 32'h3);
    repeat (8) begin
      @(negedge pclk);
      chk({sample_mode, sample_clock_phase_b, sample_clock_phase_c}, 7);
    end
    apb(1, CTRL_OFS, 0);
    repeat (2) @(negedge pclk);
    chk({source_out_enable, gate_shift_clock, gate_out_enable_c}, 1);
    apb(0, STAT_OFS, 0);
    chk(rd[1:0], 0);
  endtask : t_mode
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // Watchdog, about twice the ten thousand cycles the tests need.
  initial begin
    #1000000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(negedge pclk);
    t_reset();
    t_line();
    t_dir();
    t_scan();
    t_mode();
    give_verdict();
  end
endmodule : tb_top
